// ==== design/adt_group_timeline.sv ====
// Measurement timeline for one five-cell group; the counter advances only while run is high and holds otherwise.
// Assumes run comes from logic on the same clock.
module adt_group_timeline #(
  parameter int PERIOD_CYC = adt_pkg::TIMELINE_CYC,
  parameter int LEAD_CYC   = adt_pkg::BIAS_LEAD_CYC,
  parameter int START_CYC  = 0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      bias_en,
  output logic      meas_start
);

  logic [adt_pkg::CNT_W-1:0] cnt;
  logic                      at_end;
  logic                      at_lead;

  assign at_end  = (cnt == adt_pkg::CNT_W'(PERIOD_CYC - 1));
  assign at_lead = (cnt == adt_pkg::CNT_W'(PERIOD_CYC - 1 - LEAD_CYC));

  // ----------------------------------------------------------------
  // Period counter, own phase per group
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= adt_pkg::CNT_W'(START_CYC);
    end else if (run) begin
      cnt <= at_end ? '0 : cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Thermistor bias ahead of the measurement
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bias_en    <= 1'b0;
      meas_start <= 1'b0;
    end else begin
      meas_start <= run && at_end;
      if (!run || meas_start) begin
        bias_en <= 1'b0;
      end else if (at_lead) begin
        bias_en <= 1'b1;
      end
    end
  end

  period_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    run && at_end |=> cnt == '0)
    else $error("timeline did not wrap at period end");

  bias_lead_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(bias_en) |-> $past(cnt) == adt_pkg::CNT_W'(PERIOD_CYC - 1 - LEAD_CYC))
    else $error("bias switched on at wrong time");

  bias_before_meas_a: assert property (@(posedge clk) disable iff (!rst_b)
    meas_start |-> $past(bias_en))
    else $error("measurement started without bias");

endmodule

// ==== design/adt_pkg.sv ====
// Shared constants and carrier types for the converter trim and timeline block.
// Assumes a single 40 MHz clock and byte-wide register accesses from the serial link.
package adt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN_HI  = 8'h50;
  localparam logic [7:0] ADDR_OFFSET   = 8'h51;
  localparam logic [7:0] ADDR_GAIN_LO  = 8'h59;
  localparam logic [7:0] ADDR_READ_HI  = 8'h2c;
  localparam logic [7:0] ADDR_READ_LO  = 8'h2d;
  localparam int         GAIN_HI_POS   = 2;
  localparam int         GAIN_LO_POS   = 5;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ          = 40000;
  localparam int TIMELINE_MS      = 250;
  localparam int BIAS_LEAD_US     = 37500;
  localparam int ALERT_TAU_US     = 250;
  localparam int TIMELINE_CYC     = TIMELINE_MS * CLK_KHZ;
  localparam int BIAS_LEAD_CYC    = (BIAS_LEAD_US * (CLK_KHZ / 1000));
  localparam int ALERT_SETTLE_CYC = (ALERT_TAU_US * (CLK_KHZ / 1000));
  localparam int ALERT_DRIVE_CYC  = 4;
  localparam int NUM_GROUPS       = 3;
  localparam int CNT_W            = 24;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] gain;
    logic [7:0] offset;
  } adt_trim_t;

  typedef struct packed {
    logic       txn_start;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adt_req_t;

  typedef enum logic [1:0] {AL_IDLE, AL_HIGH, AL_CLEAR, AL_SETTLE} adt_alert_state_t;

endpackage

// ==== design/adt_trim_timeline.sv ====
// Production trim registers, per-group timelines, boot edge, alert pin and ready fault.
// Assumes byte register requests from the serial link logic on clk; pins are asynchronous.
// Trim values arrive on static fuse lines and are captured after reset release.

module adt_trim_timeline #(
  parameter int PERIOD_CYC = adt_pkg::TIMELINE_CYC,
  parameter int LEAD_CYC   = adt_pkg::BIAS_LEAD_CYC,
  parameter int SETTLE_CYC = adt_pkg::ALERT_SETTLE_CYC
) (
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  input  wire adt_pkg::adt_trim_t                 trim_fuse,
  input  wire adt_pkg::adt_req_t                  req,
  input  wire logic [13:0]                        conv_reading,
  input  wire logic                               first_thermistor_input,
  input  wire logic [adt_pkg::NUM_GROUPS-1:0]     thermistor_inputs_open,
  input  wire logic                               shutdown,
  input  wire logic                               fault_clear,
  input  wire logic                               alert_set,
  input  wire logic                               alert_clear,
  input  wire logic                               alert_i,
  output logic                                    alert_o,
  output logic                                    alert_oe,
  output logic                                    alert_level,
  output logic                                    alert_sampled,
  output logic [7:0]                              rdata,
  output logic                                    rvalid,
  output logic                                    booted,
  output logic [adt_pkg::NUM_GROUPS-1:0]          bias_en,
  output logic [adt_pkg::NUM_GROUPS-1:0]          meas_start,
  output logic [adt_pkg::NUM_GROUPS-1:0]          device_not_ready_fault
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = adt_pkg::NUM_GROUPS + 2;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic              ts1_s;
  logic              ts1_d;
  logic              alert_s;
  logic [adt_pkg::NUM_GROUPS-1:0] open_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
      ts1_d  <= 1'b0;
    end else begin
      sync_a <= {thermistor_inputs_open, alert_i, first_thermistor_input};
      sync_b <= sync_a;
      ts1_d  <= ts1_s;
    end
  end

  assign ts1_s   = sync_b[0];
  assign alert_s = sync_b[1];
  assign open_s  = sync_b[SYNC_W-1:2];

  // ----------------------------------------------------------------
  // Trim capture, one cycle after reset release
  // ----------------------------------------------------------------
  adt_pkg::adt_trim_t trim_q;
  logic               trim_loaded;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_q      <= '0;
      trim_loaded <= 1'b0;
    end else if (!trim_loaded) begin
      trim_q      <= trim_fuse;
      trim_loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register reads; writes to trims have no effect
  // ----------------------------------------------------------------
  logic [13:0] snap;
  logic        pair_open;
  logic [7:0]  next_rdata;

  always_comb begin
    next_rdata = adt_pkg::UNMAPPED_DATA;
    case (req.addr)
      adt_pkg::ADDR_GAIN_HI: begin
        next_rdata = {4'h0, trim_q.gain[4:3], 2'h0};
      end
      adt_pkg::ADDR_GAIN_LO: begin
        next_rdata = {trim_q.gain[2:0], 5'h00};
      end
      adt_pkg::ADDR_OFFSET: begin
        next_rdata = trim_q.offset;
      end
      adt_pkg::ADDR_READ_HI: begin
        next_rdata = {2'h0, conv_reading[13:8]};
      end
      adt_pkg::ADDR_READ_LO: begin
        next_rdata = pair_open ? snap[7:0] : conv_reading[7:0];
      end
      default: begin
        next_rdata = adt_pkg::UNMAPPED_DATA;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // Snapshot taken on the high byte, held until the low byte is read or a new transaction starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      snap      <= '0;
      pair_open <= 1'b0;
    end else if (req.rd && req.addr == adt_pkg::ADDR_READ_HI) begin
      snap      <= conv_reading;
      pair_open <= 1'b1;
    end else if (req.txn_start || (req.rd && req.addr == adt_pkg::ADDR_READ_LO)) begin
      pair_open <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Boot on first thermistor input edge
  // ----------------------------------------------------------------
  logic ts1_rise;
  assign ts1_rise = ts1_s && !ts1_d;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      booted <= 1'b0;
    end else if (shutdown) begin
      booted <= 1'b0;
    end else if (ts1_rise) begin
      booted <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Group timelines and not-ready fault
  // ----------------------------------------------------------------
  for (genvar g = 0; g < adt_pkg::NUM_GROUPS; g++) begin : g_grp
    adt_group_timeline #(
      .PERIOD_CYC (PERIOD_CYC),
      .LEAD_CYC   (LEAD_CYC),
      .START_CYC  ((PERIOD_CYC / adt_pkg::NUM_GROUPS) * g)
    ) u_tl (
      .clk        (clk),
      .rst_b      (rst_b),
      .run        (booted),
      .bias_en    (bias_en[g]),
      .meas_start (meas_start[g])
    );

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        device_not_ready_fault[g] <= 1'b0;
      end else if (meas_start[g] && open_s[g]) begin
        device_not_ready_fault[g] <= 1'b1;
      end else if (fault_clear) begin
        device_not_ready_fault[g] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert pin: drive, clear low, release, settle, sample
  // ----------------------------------------------------------------
  adt_pkg::adt_alert_state_t al_state;
  logic [13:0]               al_cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      al_state      <= adt_pkg::AL_IDLE;
      al_cnt        <= '0;
      alert_o       <= 1'b0;
      alert_oe      <= 1'b0;
      alert_level   <= 1'b0;
      alert_sampled <= 1'b0;
    end else begin
      alert_sampled <= 1'b0;
      case (al_state)
        adt_pkg::AL_IDLE, adt_pkg::AL_HIGH: begin
          if (alert_clear) begin
            al_state <= adt_pkg::AL_CLEAR;
            al_cnt   <= 14'(adt_pkg::ALERT_DRIVE_CYC - 1);
            alert_o  <= 1'b0;
            alert_oe <= 1'b1;
          end else if (alert_set) begin
            al_state <= adt_pkg::AL_HIGH;
            alert_o  <= 1'b1;
            alert_oe <= 1'b1;
          end
        end
        adt_pkg::AL_CLEAR: begin
          if (al_cnt == '0) begin
            al_state <= adt_pkg::AL_SETTLE;
            al_cnt   <= 14'(SETTLE_CYC - 1);
            alert_oe <= 1'b0;
          end else begin
            al_cnt <= al_cnt - 1'b1;
          end
        end
        adt_pkg::AL_SETTLE: begin
          if (al_cnt == '0) begin
            al_state      <= adt_pkg::AL_IDLE;
            alert_level   <= alert_s;
            alert_sampled <= 1'b1;
          end else begin
            al_cnt <= al_cnt - 1'b1;
          end
        end
        default: begin
          al_state <= adt_pkg::AL_IDLE;
          alert_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  gain_hi_map_a: assert property (req.rd && req.addr == adt_pkg::ADDR_GAIN_HI
    |=> rdata == {4'h0, trim_q.gain[4:3], 2'h0} && rvalid)
    else $error("gain high byte misplaced");

  gain_lo_map_a: assert property (req.rd && req.addr == adt_pkg::ADDR_GAIN_LO
    |=> rdata == {trim_q.gain[2:0], 5'h00} && rvalid)
    else $error("gain low byte misplaced");

  trim_read_only_a: assert property (trim_loaded && req.wr |=> $stable(trim_q))
    else $error("trim changed by a write");

  pair_snapshot_a: assert property (pair_open && !req.rd |=> $stable(snap))
    else $error("reading snapshot moved inside a pair");

  boot_edge_a: assert property (ts1_rise && !shutdown |=> booted)
    else $error("rising edge did not boot");

  boot_level_a: assert property (!booted && !ts1_rise |=> !booted)
    else $error("booted without an edge");

  sequence clear_drive_s;
    (alert_oe && !alert_o) [*4];
  endsequence

  alert_clear_a: assert property ($rose(al_state == adt_pkg::AL_CLEAR)
    |-> clear_drive_s ##1 !alert_oe)
    else $error("alert clear drive wrong length");

  alert_sample_a: assert property (alert_sampled
    |-> $past(al_state) == adt_pkg::AL_SETTLE && !$past(alert_oe))
    else $error("alert sampled while driven");

  fault_set_a: assert property (meas_start[0] && open_s[0] |=> device_not_ready_fault[0])
    else $error("open thermistor not flagged");

endmodule

// ==== verif/adt_host_model.sv ====
// Host partner: byte reads and writes on the request port, trim arithmetic, alert pin.
// Assumes the request port is sampled on the rising edge of clk.
module adt_host_model (
  input  wire logic         clk,
  input  wire logic         alert_o,
  input  wire logic         alert_oe,
  input  wire logic [7:0]   rdata,
  input  wire logic         rvalid,
  output adt_pkg::adt_req_t req,
  output logic              alert_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       pin;
  logic [2:0] filt = '0;
  logic       ext_hold = 1'b0;

  // Pulldown on the released pin, unless an outside party holds it high
  assign pin = alert_oe ? alert_o : ext_hold;
  assign alert_i = filt[2];

  initial begin
    req = '0;
  end

  // Short RC filter, well inside the settle time
  always @(posedge clk) begin
    filt <= {filt[1:0], pin};
  end

  // ----------------------------------------------------------------
  // Requests and trim arithmetic
  // ----------------------------------------------------------------
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] d, output logic ok);
    @(negedge clk);
    req.rd    = ~w;
    req.wr    = w;
    req.addr  = a;
    req.wdata = wd;
    @(negedge clk);
    req.rd = 1'b0;
    req.wr = 1'b0;
    // Answer stands from the taking edge until the next rising edge
    ok = w ? 1'b1 : rvalid;
    d  = rdata;
  endtask

  task automatic txn();
    @(negedge clk);
    req.txn_start = 1'b1;
    @(negedge clk);
    req.txn_start = 1'b0;
  endtask

  function automatic int gain_uv(input logic [4:0] code);
    return 365 + code;
  endfunction

  function automatic int offset_mv(input logic [7:0] code);
    return int'($signed(code));
  endfunction

  // Reading to microvolts: raw times the gain step plus the offset in millivolts times 1000
  function automatic int volts_uv(input int raw, input logic [4:0] g, input logic [7:0] o);
    return raw * gain_uv(g) + offset_mv(o) * 1000;
  endfunction
endmodule

// ==== verif/adt_trim_and_timeline_bench.sv ====
// Self-checking bench for the trim registers, timelines, boot edge and alert pin.
// Assumes shortened timeline parameters; host model drives the request port.
module adc_trim_and_timeline_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PER  = 300;
  localparam int LEAD = 40;
  localparam int SET  = 10;

  logic                clk = 1'b0;
  logic                rst_b;
  adt_pkg::adt_trim_t  trim_fuse;
  adt_pkg::adt_req_t   req;
  logic [13:0]         conv_reading;
  logic                first_thermistor_input;
  logic [2:0]          thermistor_inputs_open;
  logic                shutdown;
  logic                fault_clear;
  logic                alert_set;
  logic                alert_clear;
  logic                alert_i;
  logic                alert_o;
  logic                alert_oe;
  logic                alert_level;
  logic                alert_sampled;
  logic [7:0]          rdata;
  logic                rvalid;
  logic                booted;
  logic [2:0]          bias_en;
  logic [2:0]          meas_start;
  logic [2:0]          device_not_ready_fault;
  int                  fail_count = 0;
  int                  total_checks = 0;
  int                  n;

  always #12.5 clk = ~clk;

  adt_trim_timeline #(.PERIOD_CYC(PER), .LEAD_CYC(LEAD), .SETTLE_CYC(SET)) u_dut (
    .clk(clk), .rst_b(rst_b), .trim_fuse(trim_fuse), .req(req),
    .conv_reading(conv_reading), .first_thermistor_input(first_thermistor_input),
    .thermistor_inputs_open(thermistor_inputs_open), .shutdown(shutdown),
    .fault_clear(fault_clear), .alert_set(alert_set), .alert_clear(alert_clear),
    .alert_i(alert_i), .alert_o(alert_o), .alert_oe(alert_oe), .alert_level(alert_level),
    .alert_sampled(alert_sampled), .rdata(rdata), .rvalid(rvalid), .booted(booted),
    .bias_en(bias_en), .meas_start(meas_start),
    .device_not_ready_fault(device_not_ready_fault));

  adt_host_model u_host (
    .clk(clk), .alert_o(alert_o), .alert_oe(alert_oe), .rdata(rdata),
    .rvalid(rvalid), .req(req), .alert_i(alert_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic rd_get(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    u_host.access(1'b0, a, 8'h00, d, ok);
    check(ok, 1'b1);
  endtask

  task automatic wait_on(input logic bias, input int g, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (((bias ? bias_en[g] : meas_start[g]) !== 1'b1) && k < 1000);
    if (k >= 1000) check(1'b0, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_trim(input logic [4:0] g, input logic [7:0] o, input int uv, input int mv);
    logic [7:0] hi, lo, d;
    logic       ok;
    cyc(1);
    trim_fuse.gain   = g;
    trim_fuse.offset = o;
    rst_b = 1'b0;
    cyc(5);
    rst_b = 1'b1;
    cyc(3);
    rd_get(adt_pkg::ADDR_GAIN_HI, hi);
    rd_get(adt_pkg::ADDR_GAIN_LO, lo);
    check(hi, {4'h0, g[4:3], 2'h0});
    check(lo, {g[2:0], 5'h00});
    check(u_host.gain_uv({hi[3:2], lo[7:5]}), uv);
    u_host.access(1'b1, adt_pkg::ADDR_OFFSET, ~o, d, ok);
    u_host.access(1'b1, adt_pkg::ADDR_GAIN_HI, ~hi, d, ok);
    rd_get(adt_pkg::ADDR_OFFSET, d);
    check(d, o);
    check(u_host.offset_mv(d), mv);
    rd_get(adt_pkg::ADDR_GAIN_HI, d);
    check(d, hi);
    rd_get(8'h52, d);
    check(d, adt_pkg::UNMAPPED_DATA);
  endtask

  task automatic t_pair();
    logic [7:0] d;
    cyc(1);
    conv_reading = 14'h2abc;
    rd_get(adt_pkg::ADDR_READ_HI, d);
    check(d, 8'h2a);
    cyc(1);
    conv_reading = 14'h1111;
    rd_get(adt_pkg::ADDR_READ_LO, d);
    check(d, 8'hbc);
    u_host.txn();
    rd_get(adt_pkg::ADDR_READ_LO, d);
    check(d, 8'h11);
  endtask

  task automatic t_boot();
    cyc(1);
    first_thermistor_input = 1'b1;
    cyc(6);
    check(booted, 1'b1);
    shutdown = 1'b1;
    cyc(1);
    shutdown = 1'b0;
    cyc(10);
    check(booted, 1'b0);
    first_thermistor_input = 1'b0;
    cyc(4);
    first_thermistor_input = 1'b1;
    cyc(6);
    check(booted, 1'b1);
  endtask

  task automatic t_time();
    wait_on(1'b0, 0, n);
    cyc(3);
    wait_on(1'b1, 0, n);
    wait_on(1'b0, 0, n);
    check(n, LEAD);
    wait_on(1'b0, 1, n);
    check(n, PER * 2 / 3);
    wait_on(1'b0, 0, n);
    check(n, PER / 3);
  endtask

  task automatic t_fault();
    thermistor_inputs_open = 3'b100;
    wait_on(1'b0, 2, n);
    cyc(2);
    check(device_not_ready_fault, 3'b100);
    thermistor_inputs_open = 3'b000;
    fault_clear = 1'b1;
    cyc(1);
    fault_clear = 1'b0;
    cyc(2);
    check(device_not_ready_fault, 3'b000);
  endtask

  task automatic t_alert();
    alert_set = 1'b1;
    cyc(1);
    alert_set = 1'b0;
    cyc(5);
    check({alert_oe, alert_o}, 2'b11);
    alert_clear = 1'b1;
    cyc(1);
    alert_clear = 1'b0;
    for (int i = 0; i < adt_pkg::ALERT_DRIVE_CYC; i++) begin
      check({alert_oe, alert_o}, 2'b10);
      cyc(1);
    end
    check(alert_oe, 1'b0);
    alert_set = 1'b1;
    cyc(1);
    alert_set = 1'b0;
    check(alert_oe, 1'b0);
    n = 0;
    while (alert_sampled !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n, SET - 1);
    check(alert_level, 1'b0);
    u_host.ext_hold = 1'b1;
    alert_clear = 1'b1;
    cyc(1);
    alert_clear = 1'b0;
    n = 0;
    while (alert_sampled !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n, adt_pkg::ALERT_DRIVE_CYC + SET);
    check(alert_level, 1'b1);
    u_host.ext_hold = 1'b0;
  endtask

  initial begin
    rst_b = 1'b0;
    trim_fuse = '0;
    conv_reading = '0;
    first_thermistor_input = 1'b0;
    thermistor_inputs_open = '0;
    shutdown = 1'b0;
    fault_clear = 1'b0;
    alert_set = 1'b0;
    alert_clear = 1'b0;
    t_trim(5'h1b, 8'h80, 392, -128);
    t_trim(5'h04, 8'h7f, 369, 127);
    t_pair();
    t_boot();
    t_time();
    t_fault();
    t_alert();
    close_out();
  end

  initial begin
    #500000;
    fail_count++;
    close_out();
  end
endmodule
